// ---- verilog/ctc_pkg.sv ----
// Purpose: Shared constants and types for the cyclic timer channel
// Assumes: One 100 MHz clock, events are one-cycle pulses
// Notes: Channel index map: 0-7 physical, 8-15 virtual, 16-19 logic,
//   20-23 timer
`default_nettype none
package ctc_pkg;
  // Clock and seconds tick
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES =
    (TICK_PERIOD_S * 1000000000) / CLK_PERIOD_NS;

  // Field widths and limits
  localparam int unsigned DUR_W = 15;
  localparam int unsigned CYC_W = 8;
  localparam int unsigned SEL_W = 5;
  localparam logic [DUR_W-1:0] DUR_MAX = 15'h7530;
  localparam logic [CYC_W-1:0] CYC_NONE = 8'h00;

  // Trigger sources
  localparam int unsigned NUM_PHYS = 8;
  localparam int unsigned NUM_VIRT = 8;
  localparam int unsigned NUM_LOGIC = 4;
  localparam int unsigned NUM_TIMER = 4;
  localparam int unsigned NUM_SRC =
    NUM_PHYS + NUM_VIRT + NUM_LOGIC + NUM_TIMER;

  // Reset values
  localparam logic [DUR_W-1:0] SEC_RST = 15'h0000;
  localparam logic [CYC_W-1:0] CNT_RST = 8'h00;

  // Control pair choice
  typedef enum logic
  {
    PAIR_PRESS = 1'b0,
    PAIR_EDGE = 1'b1
  } ctc_pair_e;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ON = 2'b01,
    ST_OFF = 2'b10
  } ctc_state_e;

  // One channel's event set
  typedef struct packed
  {
    logic shortPress;
    logic longPress;
    logic rise;
    logic fall;
  } ctc_evt_s;

  // Static configuration
  typedef struct packed
  {
    logic [DUR_W-1:0] onTime;
    logic [DUR_W-1:0] offTime;
    logic [CYC_W-1:0] cycleLimit;
    ctc_pair_e pairSel;
    logic [SEL_W-1:0] trigSel;
    logic autoStart;
    logic longAtEnd;
  } ctc_cfg_s;
endpackage
`default_nettype wire

// ---- verilog/ctc_sec_tick.sv ----
// Purpose: Seconds tick divider for the timer channel
// Assumes: Clear realigns the tick phase
// Notes: Pulse lasts one cycle, every TICK_CYCLES cycles
`default_nettype none
module ctc_sec_tick #(
  parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control
  input wire logic clr,
  output logic tick
);
  generate
    if (TICK_CYCLES < 2)
    begin
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  typedef struct packed
  {
    logic [31:0] cnt;
    logic tick;
  } ctc_tick_s;

  ctc_tick_s st_ff;
  ctc_tick_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (clr)
    begin
      nxt_st.cnt = 32'h0000_0000;
    end
    else if (st_ff.cnt == TICK_CYCLES - 1)
    begin
      // Period counted from a clear, so a phase lasts whole seconds
      nxt_st.cnt = 32'h0000_0000;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule
`default_nettype wire

// ---- verilog/ctc_timer_channel.sv ----
// Purpose: Cyclic timer channel with ON/OFF phases and channel events
// Assumes: Trigger events come from same-clock logic as one-cycle pulses
// Notes: Reset release stands for bus recovery
`default_nettype none
module ctc_timer_channel #(
  parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration
  input wire ctc_pkg::ctc_cfg_s cfg,
  // Trigger channel events, index per source map
  input wire ctc_pkg::ctc_evt_s [ctc_pkg::NUM_SRC-1:0] srcEvt,
  // Channel outputs
  output ctc_pkg::ctc_evt_s chanEvt,
  output logic chanState,
  output logic timerEnabled,
  output logic [ctc_pkg::CYC_W-1:0] cycleCount
);
  generate
    if (TICK_CYCLES < 2)
    begin
      $error("TICK_CYCLES must be at least 2");
    end
    if (ctc_pkg::NUM_SRC > (1 << ctc_pkg::SEL_W))
    begin
      $error("Source select too narrow for the source map");
    end
  endgenerate

  typedef struct packed
  {
    ctc_pkg::ctc_state_e state;
    logic [ctc_pkg::DUR_W-1:0] secCnt;
    logic [ctc_pkg::CYC_W-1:0] cycCnt;
    logic booted;
    logic chanOn;
    logic enabled;
    ctc_pkg::ctc_evt_s evt;
  } ctc_main_s;

  ctc_main_s st_ff;
  ctc_main_s nxt_st;
  ctc_pkg::ctc_evt_s selEvt;
  logic startEvt;
  logic stopEvt;
  logic tick;
  logic tickClr;
  logic [ctc_pkg::DUR_W-1:0] onLen;
  logic [ctc_pkg::DUR_W-1:0] offLen;
  logic [ctc_pkg::CYC_W-1:0] cycNext;

  // Values above the range act as the maximum
  function automatic logic [ctc_pkg::DUR_W-1:0] clampDur(
    input logic [ctc_pkg::DUR_W-1:0] d
  );
    clampDur = (d > ctc_pkg::DUR_MAX) ? ctc_pkg::DUR_MAX : d;
  endfunction

  // Phase over once elapsed seconds reach its length
  function automatic logic phaseDone(
    input logic [ctc_pkg::DUR_W-1:0] cnt,
    input logic [ctc_pkg::DUR_W-1:0] len
  );
    phaseDone = (cnt >= len);
  endfunction

  assign onLen = clampDur(cfg.onTime);
  assign offLen = clampDur(cfg.offTime);
  assign cycNext = st_ff.cycCnt + ctc_pkg::CYC_W'(1);

  // Only the chosen source is looked at
  always_comb
  begin
    selEvt = '0;
    if (cfg.trigSel < ctc_pkg::SEL_W'(ctc_pkg::NUM_SRC))
    begin
      selEvt = srcEvt[cfg.trigSel];
    end
  end

  // Pair choice maps the source events onto start and stop
  always_comb
  begin
    if (cfg.pairSel == ctc_pkg::PAIR_EDGE)
    begin
      startEvt = selEvt.rise;
      stopEvt = selEvt.fall;
    end
    else
    begin
      startEvt = selEvt.shortPress;
      stopEvt = selEvt.longPress;
    end
  end

  // Tick phase restarts with every phase so a phase is whole seconds
  assign tickClr = (st_ff.state == ctc_pkg::ST_IDLE) ||
                   (nxt_st.state != st_ff.state) ||
                   (nxt_st.secCnt == ctc_pkg::SEC_RST &&
                    st_ff.secCnt != ctc_pkg::SEC_RST);

  ctc_sec_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .clr(tickClr),
    .tick(tick)
  );

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.evt = '0;
    nxt_st.booted = 1'b1;
    case (st_ff.state)
      ctc_pkg::ST_IDLE:
      begin
        // First cycle after release decides autostart
        if ((!st_ff.booted && cfg.autoStart) || startEvt)
        begin
          nxt_st.state = ctc_pkg::ST_ON;
          nxt_st.secCnt = ctc_pkg::SEC_RST;
          nxt_st.cycCnt = ctc_pkg::CNT_RST;
          nxt_st.evt.shortPress = 1'b1;
          nxt_st.evt.rise = 1'b1;
        end
      end
      ctc_pkg::ST_ON:
      begin
        if (stopEvt)
        begin
          nxt_st.state = ctc_pkg::ST_IDLE;
          nxt_st.evt.fall = 1'b1;
        end
        else if (phaseDone(st_ff.secCnt, onLen))
        begin
          nxt_st.state = ctc_pkg::ST_OFF;
          nxt_st.secCnt = ctc_pkg::SEC_RST;
          nxt_st.evt.fall = 1'b1;
        end
        else if (tick)
        begin
          nxt_st.secCnt = st_ff.secCnt + ctc_pkg::DUR_W'(1);
        end
      end
      ctc_pkg::ST_OFF:
      begin
        if (stopEvt)
        begin
          // Already low, so no edge event on this stop
          nxt_st.state = ctc_pkg::ST_IDLE;
        end
        else if (phaseDone(st_ff.secCnt, offLen))
        begin
          nxt_st.secCnt = ctc_pkg::SEC_RST;
          nxt_st.cycCnt = cycNext;
          if (cfg.cycleLimit != ctc_pkg::CYC_NONE &&
              cycNext == cfg.cycleLimit)
          begin
            nxt_st.state = ctc_pkg::ST_IDLE;
            nxt_st.evt.longPress = cfg.longAtEnd;
          end
          else
          begin
            // Counter wraps when running forever
            nxt_st.state = ctc_pkg::ST_ON;
            nxt_st.evt.shortPress = 1'b1;
            nxt_st.evt.rise = 1'b1;
          end
        end
        else if (tick)
        begin
          nxt_st.secCnt = st_ff.secCnt + ctc_pkg::DUR_W'(1);
        end
      end
      default:
      begin
        nxt_st.state = ctc_pkg::ST_IDLE;
      end
    endcase
    // Levels kept in flip-flops so outputs carry no decode glitches
    nxt_st.chanOn = (nxt_st.state == ctc_pkg::ST_ON);
    nxt_st.enabled = (nxt_st.state != ctc_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign chanEvt = st_ff.evt;
  assign chanState = st_ff.chanOn;
  assign timerEnabled = st_ff.enabled;
  assign cycleCount = st_ff.cycCnt;
endmodule
`default_nettype wire

// ---- verification/ctc_timer_channel_asserts.sv ----
// Purpose: Port checks for the cyclic timer channel
// Assumes: Sees only the top module ports
// Notes: Start check skips selects past the source map
`default_nettype none
module ctc_timer_channel_asserts #(
  parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Inputs
  input wire ctc_pkg::ctc_cfg_s cfg,
  input wire ctc_pkg::ctc_evt_s [ctc_pkg::NUM_SRC-1:0] srcEvt,
  // Outputs
  input wire ctc_pkg::ctc_evt_s chanEvt,
  input wire logic chanState,
  input wire logic timerEnabled,
  input wire logic [ctc_pkg::CYC_W-1:0] cycleCount
);
  timeunit 1ns;
  timeprecision 1ns;
  ctc_pkg::ctc_evt_s sel;
  logic okSel;
  logic startHit;
  logic stopHit;
  assign sel = srcEvt[cfg.trigSel];
  assign okSel = cfg.trigSel < 5'h18;
  assign startHit = okSel && (cfg.pairSel ? sel.rise : sel.shortPress);
  assign stopHit = okSel && (cfg.pairSel ? sel.fall : sel.longPress);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_rise; chanEvt.rise == $rose(chanState); endproperty
  a_rise: assert property (p_rise) else $error("rise event mismatch");
  property p_fall; chanEvt.fall == $fell(chanState); endproperty
  a_fall: assert property (p_fall) else $error("fall event mismatch");
  property p_idle; !timerEnabled |-> !chanState && !chanEvt.rise
    && !chanEvt.shortPress; endproperty
  a_idle: assert property (p_idle) else $error("idle not low");
  property p_short; chanEvt.shortPress |-> chanState && timerEnabled;
  endproperty
  a_short: assert property (p_short) else $error("stray short");
  property p_long; chanEvt.longPress |-> !timerEnabled && cfg.longAtEnd
    && cfg.cycleLimit != 8'h00 && cycleCount == cfg.cycleLimit; endproperty
  a_long: assert property (p_long) else $error("bad long");
  property p_start; !timerEnabled && startHit |=> timerEnabled
    && chanState && cycleCount == 8'h00; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop; timerEnabled && stopHit |=> !timerEnabled; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_forever; $fell(timerEnabled) && cfg.cycleLimit == 8'h00
    |-> $past(stopHit); endproperty
  a_forever: assert property (p_forever) else $error("self stop");
endmodule
bind ctc_timer_channel ctc_timer_channel_asserts #(
  .TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk(mclk), .arst_n(arst_n),
  .cfg(cfg), .srcEvt(srcEvt), .chanEvt(chanEvt), .chanState(chanState),
  .timerEnabled(timerEnabled), .cycleCount(cycleCount));
`default_nettype wire

// ---- verification/ctc_src_model.sv ----
// Purpose: Trigger source channels for the timer channel
// Assumes: Sources give one-cycle pulses on mclk
// Notes: Lag lets a source answer late
`default_nettype none
module ctc_src_model
(
  // Clock
  input wire logic mclk,
  // Source events
  output ctc_pkg::ctc_evt_s [ctc_pkg::NUM_SRC-1:0] srcEvt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial srcEvt = '0;
  task automatic fire(input int idx, input logic [3:0] e, input int lag);
    repeat (lag) @(posedge mclk);
    @(posedge mclk);
    srcEvt[idx] <= e;
    @(posedge mclk);
    srcEvt[idx] <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ---- verification/test_ctc_timer_channel.sv ----
// Purpose: Self-checking bench for the cyclic timer channel
// Assumes: Seconds tick cut to 10 clocks
// Notes: A monitor counts channel events
`default_nettype none
module test_ctc_timer_channel;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk;
  logic arst_n;
  ctc_pkg::ctc_cfg_s cfg;
  ctc_pkg::ctc_evt_s [ctc_pkg::NUM_SRC-1:0] srcEvt;
  ctc_pkg::ctc_evt_s chanEvt;
  logic chanState;
  logic timerEnabled;
  logic [7:0] cycleCount;
  int err_count = 0;
  int checked = 0;
  int nS = 0;
  int nL = 0;
  int nR = 0;
  int nF = 0;
  int cyc;
  ctc_timer_channel #(.TICK_CYCLES(10)) dut (.mclk(mclk),
    .arst_n(arst_n), .cfg(cfg), .srcEvt(srcEvt), .chanEvt(chanEvt),
    .chanState(chanState), .timerEnabled(timerEnabled),
    .cycleCount(cycleCount));
  ctc_src_model src (.mclk(mclk), .srcEvt(srcEvt));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    nS += chanEvt.shortPress === 1'b1;
    nL += chanEvt.longPress === 1'b1;
    nR += chanEvt.rise === 1'b1;
    nF += chanEvt.fall === 1'b1;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic wait_idle();
    for (cyc = 0; cyc < 300 && timerEnabled !== 1'b0; cyc++)
      @(posedge mclk);
    #1;
  endtask
  task automatic set_cfg(input logic [14:0] on, input logic [14:0] off,
    input logic [7:0] lim, input logic pr, input logic [4:0] s,
    input logic lae);
    @(posedge mclk);
    cfg <= {on, off, lim, pr, s, 1'b0, lae};
    #1;
    nS = 0;
    nL = 0;
    nR = 0;
    nF = 0;
  endtask
  task automatic t_auto();
    @(posedge mclk);
    #1;
    chk(timerEnabled, 1);
    wait_idle();
    chk(cyc >= 38 && cyc <= 60, 1);
    chk(nS, 2);
    chk(nR, 2);
    chk(nF, 2);
    chk(nL, 1);
    chk(cycleCount, 2);
  endtask
  task automatic t_press();
    set_cfg(1, 0, 0, ctc_pkg::PAIR_PRESS, 9, 1);
    src.fire(3, 4'h8, 0);
    #1;
    chk(timerEnabled, 0);
    src.fire(9, 4'h4, 1);
    #1;
    chk(timerEnabled, 0);
    src.fire(9, 4'h8, 2);
    #1;
    chk({timerEnabled, chanState, cycleCount}, 10'h300);
    repeat (100) @(posedge mclk);
    #1;
    chk({timerEnabled, 7'h00}, 8'h80);
    chk(nL, 0);
    chk(nS >= 2 && nS <= 11, 1);
    src.fire(9, 4'h4, 0);
    #1;
    chk({timerEnabled, chanState}, 0);
  endtask
  task automatic t_edge();
    set_cfg(0, 2, 1, ctc_pkg::PAIR_EDGE, 20, 0);
    src.fire(20, 4'h8, 0);
    #1;
    chk(timerEnabled, 0);
    src.fire(20, 4'h2, 1);
    #1;
    chk({timerEnabled, cycleCount}, 9'h100);
    wait_idle();
    chk(nS, 1);
    chk(nL, 0);
    chk(cycleCount, 1);
    src.fire(20, 4'h2, 0);
    src.fire(20, 4'h1, 0);
    #1;
    chk(timerEnabled, 0);
  endtask
  task automatic t_reset();
    src.fire(20, 4'h2, 0);
    #1;
    chk(timerEnabled, 1);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({timerEnabled, chanState, cycleCount}, 10'h000);
  endtask
  task automatic test_done();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done();
  end
  initial
  begin
    arst_n = 1'b0;
    cfg = {15'h0001, 15'h0001, 8'h02, ctc_pkg::PAIR_PRESS, 5'h00, 2'h3};
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_auto();
    t_press();
    t_edge();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
